// file: lbsd_exec_unit.sv
// Decrement-loop branch and signed divide execution unit with data registers and flags
// Overview of operation
// - Condition true: counter, flags and flow untouched; continue with next instruction.
// - Condition false: decrement only low 16 counter bits, upper half kept.
// - Low counter reaching minus one falls through, else branch by displacement.
// - Branch base is the loop opcode word address plus two.
// - Displacement is a signed byte offset from that base.
// - Condition field picks one of sixteen flag tests.
// - Three-bit field picks counter register; loop never changes flags.
// - Word divide: 32 by 16 bits, quotient low half, remainder high half.
// - Remainder sign follows the dividend sign.
// - First long form: 32 by 32, quotient only, remainder dropped.
// - Second long form: 64-bit register pair by 32, quotient and remainder.
// - Third long form: 32 by 32 giving quotient and remainder.
// - Zero divisor aborts and raises a divide-by-zero trap.
// - Overflow, possibly early, sets overflow flag and leaves registers untouched.
// - Word form overflows when quotient does not fit 16-bit signed.
// - Sign and zero flags follow the quotient; free on overflow or trap.
// - Overflow flag set on overflow else cleared; carry cleared; extend kept.
// - Word form destination register is both dividend and result.
// - Source accepts only data addressing modes; address register direct rejected.
// - Long forms: quotient register gives low dividend and takes quotient.
// - Size bit selects 32-bit or 64-bit register-pair dividend.
// - Remainder register takes remainder and gives high dividend when size set.
// - Same register for quotient and remainder keeps only the quotient.
`timescale 1ns/1ps
module lbsd_exec_unit (
    input logic clk,
    input logic reset,
    input logic issue_valid,
    input lbsd_pkg::lbsd_issue_type issue,
    input logic [3:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_write,
    input logic reg_read,
    output logic [31:0] reg_rdata,
    output logic done,
    output logic [31:0] next_pc,
    output logic branch_taken,
    output logic div_zero_trap,
    output logic illegal_op,
    output logic busy
);

    function automatic logic [63:0] neg64(input logic [63:0] x);
        neg64 = ~x + 64'h0000_0000_0000_0001;
    endfunction : neg64

    function automatic logic [63:0] mag64(input logic [63:0] x);
        mag64 = x[63] ? neg64(x) : x;
    endfunction : mag64

    function automatic logic [31:0] sext16(input logic [15:0] x);
        sext16 = {{16{x[15]}}, x};
    endfunction : sext16

    // Signed range check on a quotient magnitude
    function automatic logic fits(input logic [63:0] mag, input logic neg, input logic [63:0] limit);
        fits = neg ? (mag <= limit) : (mag < limit);
    endfunction : fits

    lbsd_pkg::lbsd_core_type st;
    lbsd_pkg::lbsd_core_type next_st;

    logic [15:0] opw;
    logic [15:0] ext;
    logic accept;
    logic is_loop;
    logic is_wdiv;
    logic is_ldiv;
    logic ea_ok;
    logic cond_true;
    logic [2:0] loop_reg;
    logic [15:0] count_dec;
    logic [31:0] pc_after;
    logic [31:0] branch_target;
    logic [31:0] src;
    logic [31:0] divisor_val;
    logic [31:0] quo_src;
    logic [63:0] dividend_val;
    logic [63:0] dd_mag;
    logic [31:0] dv_mag;
    logic early_ovf;
    logic div_done;
    logic [63:0] div_quo;
    logic [31:0] div_rem;
    logic [63:0] q_signed;
    logic [31:0] r_signed;
    logic q_ovf;

    assign opw = issue.op_word;
    assign ext = issue.ext_word;
    assign accept = issue_valid && (st.state == lbsd_pkg::ST_IDLE);

    // Decode
    assign is_loop = (opw[15:12] == lbsd_pkg::LOOP_TOP) && (opw[7:3] == lbsd_pkg::LOOP_MID);
    assign is_wdiv = (opw[15:12] == lbsd_pkg::WORD_TOP) && (opw[8:6] == lbsd_pkg::WORD_OPMODE);
    assign is_ldiv = (opw[15:6] == lbsd_pkg::LONG_TOP) && ext[11] && !ext[15]
        && (ext[9:3] == lbsd_pkg::EXT_ZERO_FIELD);
    assign ea_ok = (opw[5:3] != lbsd_pkg::MODE_AREG)
        && !((opw[5:3] == lbsd_pkg::MODE_EXT) && (opw[2:0] > lbsd_pkg::EXT_REG_MAX));

    // Loop datapath
    assign loop_reg = opw[2:0];
    assign count_dec = st.dreg[loop_reg][15:0] - lbsd_pkg::COUNT_STEP;
    assign pc_after = issue.instr_pc + lbsd_pkg::PC_NEXT_STEP;
    assign branch_target = issue.instr_pc + lbsd_pkg::PC_BASE_STEP + sext16(ext);

    lbsd_cond_eval u_cond (
        .condition_select(opw[11:8]),
        .flags(st.flags),
        .result(cond_true)
    );

    // Divide operand setup; a data register source is read from the local file
    assign src = (opw[5:3] == lbsd_pkg::MODE_DREG) ? st.dreg[opw[2:0]] : issue.src_value;
    assign divisor_val = is_wdiv ? sext16(src[15:0]) : src;
    assign quo_src = is_wdiv ? st.dreg[opw[11:9]] : st.dreg[ext[14:12]];
    assign dividend_val = (!is_wdiv && ext[10]) ? {st.dreg[ext[2:0]], quo_src}
        : {{32{quo_src[31]}}, quo_src};
    assign dd_mag = mag64(dividend_val);
    assign dv_mag = 32'(mag64({{32{divisor_val[31]}}, divisor_val}));
    // High half not below divisor means quotient needs more than 32 bits
    assign early_ovf = dd_mag[63:32] >= dv_mag;

    lbsd_mag_divider u_div (
        .clk(clk),
        .reset(reset),
        .start(st.div_start),
        .dividend(st.dividend),
        .divisor(st.divisor),
        .done(div_done),
        .quotient(div_quo),
        .remainder(div_rem)
    );

    // Signs are reapplied after an unsigned divide
    assign q_signed = st.neg_q ? neg64(div_quo) : div_quo;
    assign r_signed = st.neg_r ? 32'(neg64({32'h0000_0000, div_rem})) : div_rem;
    assign q_ovf = !fits(div_quo, st.neg_q,
        st.word_form ? lbsd_pkg::WORD_Q_LIMIT : lbsd_pkg::LONG_Q_LIMIT);

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.branch_taken = 1'b0;
        next_st.div_zero_trap = 1'b0;
        next_st.illegal_op = 1'b0;
        next_st.div_start = 1'b0;
        next_st.rd_data = 32'h0000_0000;
        if (reg_read) begin
            if (reg_addr < lbsd_pkg::REG_ADDR_FLAGS) begin
                next_st.rd_data = st.dreg[reg_addr[2:0]];
            end else if (reg_addr == lbsd_pkg::REG_ADDR_FLAGS) begin
                next_st.rd_data = {27'h000_0000, st.flags};
            end else if (reg_addr == lbsd_pkg::REG_ADDR_STATUS) begin
                next_st.rd_data = {31'h0000_0000, st.busy};
            end
        end
        // Execution below overrides a port write to the same register in one cycle
        if (reg_write) begin
            if (reg_addr < lbsd_pkg::REG_ADDR_FLAGS) begin
                next_st.dreg[reg_addr[2:0]] = reg_wdata;
            end else if (reg_addr == lbsd_pkg::REG_ADDR_FLAGS) begin
                next_st.flags = reg_wdata[4:0];
            end
        end
        case (st.state)
            lbsd_pkg::ST_IDLE: begin
                if (issue_valid) begin
                    next_st.done = 1'b1;
                    next_st.next_pc = pc_after;
                    if (is_loop) begin
                        if (!cond_true) begin
                            next_st.dreg[loop_reg][15:0] = count_dec;
                            if (count_dec != lbsd_pkg::COUNT_END) begin
                                next_st.next_pc = branch_target;
                                next_st.branch_taken = 1'b1;
                            end
                        end
                    end else if (!(is_wdiv || is_ldiv) || !ea_ok) begin
                        next_st.illegal_op = 1'b1;
                    end else if (divisor_val == 32'h0000_0000) begin
                        next_st.div_zero_trap = 1'b1;
                        next_st.flags.c = 1'b0;
                    end else if (is_ldiv && early_ovf) begin
                        next_st.flags.v = 1'b1;
                        next_st.flags.c = 1'b0;
                    end else begin
                        next_st.done = 1'b0;
                        next_st.state = lbsd_pkg::ST_DIV_RUN;
                        next_st.busy = 1'b1;
                        next_st.div_start = 1'b1;
                        next_st.word_form = is_wdiv;
                        next_st.neg_q = dividend_val[63] ^ divisor_val[31];
                        next_st.neg_r = dividend_val[63];
                        next_st.quo_reg = is_wdiv ? opw[11:9] : ext[14:12];
                        next_st.rem_reg = ext[2:0];
                        next_st.write_rem = ext[14:12] != ext[2:0];
                        next_st.dividend = dd_mag;
                        next_st.divisor = dv_mag;
                    end
                end
            end
            lbsd_pkg::ST_DIV_RUN: begin
                if (div_done) begin
                    next_st.state = lbsd_pkg::ST_IDLE;
                    next_st.busy = 1'b0;
                    next_st.done = 1'b1;
                    next_st.flags.c = 1'b0;
                    next_st.flags.v = q_ovf;
                    if (!q_ovf) begin
                        if (st.word_form) begin
                            next_st.flags.n = q_signed[15];
                            next_st.flags.z = q_signed[15:0] == 16'h0000;
                            next_st.dreg[st.quo_reg] = {r_signed[15:0], q_signed[15:0]};
                        end else begin
                            next_st.flags.n = q_signed[31];
                            next_st.flags.z = q_signed[31:0] == 32'h0000_0000;
                            if (st.write_rem) begin
                                next_st.dreg[st.rem_reg] = r_signed;
                            end
                            next_st.dreg[st.quo_reg] = q_signed[31:0];
                        end
                    end
                end
            end
            default: begin
                next_st.state = lbsd_pkg::ST_IDLE;
                next_st.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= lbsd_pkg::CORE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rd_data;
    assign done = st.done;
    assign next_pc = st.next_pc;
    assign branch_taken = st.branch_taken;
    assign div_zero_trap = st.div_zero_trap;
    assign illegal_op = st.illegal_op;
    assign busy = st.busy;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_loop_accept;
        accept && is_loop && !reg_write;
    endsequence

    sequence s_div_launch;
        accept && (is_wdiv || is_ldiv) && ea_ok && (divisor_val != 32'h0000_0000)
            && !(is_ldiv && early_ovf);
    endsequence

    sequence s_div_busy;
        busy [*8];
    endsequence

    sequence s_div_zero_issue;
        accept && (is_wdiv || is_ldiv) && ea_ok && divisor_val == 32'h0000_0000 && !reg_write;
    endsequence

    sequence s_div_complete;
        st.state == lbsd_pkg::ST_DIV_RUN && div_done;
    endsequence

    a_loop_true_hold: assert property (s_loop_accept and cond_true |=> done && !branch_taken
        && (st.dreg == $past(st.dreg)) && (next_pc == $past(issue.instr_pc) + 32'h0000_0004))
        else $error("loop with true condition changed state or flow");

    a_loop_upper_keep: assert property (s_loop_accept and !cond_true |=>
        st.dreg[$past(loop_reg)][31:16] == $past(st.dreg[loop_reg][31:16])
        && st.dreg[$past(loop_reg)][15:0] == $past(st.dreg[loop_reg][15:0]) - 16'h0001)
        else $error("loop counter update wrong");

    a_loop_fall_out: assert property (s_loop_accept and !cond_true
        and (st.dreg[loop_reg][15:0] == 16'h0000) |=> !branch_taken)
        else $error("loop branched after counter reached minus one");

    a_loop_target_pc: assert property (s_loop_accept and !cond_true
        and (st.dreg[loop_reg][15:0] != 16'h0000) |=> branch_taken
        && next_pc == $past(issue.instr_pc) + 32'h0000_0002 + {{16{$past(ext[15])}}, $past(ext)})
        else $error("loop branch target wrong");

    a_loop_flags_kept: assert property (s_loop_accept |=> st.flags == $past(st.flags))
        else $error("loop changed flags");

    a_div_zero_trap: assert property (s_div_zero_issue
        |=> div_zero_trap && done && !busy && st.dreg == $past(st.dreg))
        else $error("zero divisor did not trap cleanly");

    a_div_finishes: assert property (s_div_launch |=> s_div_busy ##[50:62] done && !busy)
        else $error("divide did not finish in time");

    a_div_ovf_keep: assert property (st.state == lbsd_pkg::ST_DIV_RUN && div_done && q_ovf
        && !reg_write |=> st.flags.v && st.dreg == $past(st.dreg))
        else $error("overflow changed registers or missed flag");

    a_div_carry_clear: assert property (st.state == lbsd_pkg::ST_DIV_RUN && div_done && !reg_write
        |=> !st.flags.c && st.flags.x == $past(st.flags.x))
        else $error("divide left carry set or changed extend");

    a_ea_reject: assert property (accept && (is_wdiv || is_ldiv)
        && opw[5:3] == lbsd_pkg::MODE_AREG |=> illegal_op && done)
        else $error("address register source not rejected");

    a_div_identity: assert property (s_div_complete |-> div_rem < st.divisor
        && div_quo * 64'(st.divisor) + 64'(div_rem) == st.dividend)
        else $error("divider result does not rebuild the dividend");

    a_rem_sign_kept: assert property (s_div_complete ##0 (!q_ovf && !st.word_form && st.write_rem)
        ##0 !reg_write |=> st.dreg[st.rem_reg] == 32'h0000_0000 || st.dreg[st.rem_reg][31] == $past(st.neg_r))
        else $error("remainder sign differs from dividend sign");

    a_trap_carry_clear: assert property (s_div_zero_issue
        |=> !st.flags.c && st.flags.x == $past(st.flags.x))
        else $error("zero divisor left carry set or changed extend");

    a_early_ovf_keep: assert property (accept && is_ldiv && ea_ok && divisor_val != 32'h0000_0000 && early_ovf
        && !reg_write |=> done && !busy && st.flags.v && !st.flags.c && st.dreg == $past(st.dreg))
        else $error("early overflow changed registers or missed flag");

    a_cond_always_true: assert property (accept && is_loop && opw[11:8] == 4'h0 |-> cond_true)
        else $error("always-true condition evaluated false");

    a_cond_never_true: assert property (accept && is_loop && opw[11:8] == 4'h1 |-> !cond_true)
        else $error("always-false condition evaluated true");

    a_unsigned_reject: assert property (accept && opw[15:6] == lbsd_pkg::LONG_TOP && !ext[11]
        |=> illegal_op && done)
        else $error("long divide without signed select not rejected");

endmodule : lbsd_exec_unit

// file: lbsd_pkg.sv
// Shared constants and types for the loop-branch and signed-divide unit
package lbsd_pkg;

    // Instruction decode patterns and field limits
    localparam logic [3:0] LOOP_TOP = 4'h5;
    localparam logic [4:0] LOOP_MID = 5'h19;
    localparam logic [3:0] WORD_TOP = 4'h8;
    localparam logic [2:0] WORD_OPMODE = 3'h7;
    localparam logic [9:0] LONG_TOP = 10'h131;
    localparam logic [6:0] EXT_ZERO_FIELD = 7'h00;
    localparam logic [2:0] MODE_DREG = 3'h0;
    localparam logic [2:0] MODE_AREG = 3'h1;
    localparam logic [2:0] MODE_EXT = 3'h7;
    localparam logic [2:0] EXT_REG_MAX = 3'h4;

    // Program counter steps and loop end value
    localparam logic [31:0] PC_BASE_STEP = 32'h0000_0002;
    localparam logic [31:0] PC_NEXT_STEP = 32'h0000_0004;
    localparam logic [15:0] COUNT_END = 16'hFFFF;
    localparam logic [15:0] COUNT_STEP = 16'h0001;

    // Quotient range limits, magnitude of the most negative value
    localparam logic [63:0] WORD_Q_LIMIT = 64'h0000_0000_0000_8000;
    localparam logic [63:0] LONG_Q_LIMIT = 64'h0000_0000_8000_0000;

    // Divider sequencing
    localparam logic [6:0] DIV_LAST_STEP = 7'h3F;
    localparam logic [6:0] DIV_COUNT_RESET = 7'h00;

    // Register port map
    localparam logic [3:0] REG_ADDR_FLAGS = 4'h8;
    localparam logic [3:0] REG_ADDR_STATUS = 4'h9;

    typedef enum logic [3:0] {
        COND_TRUE, COND_FALSE, COND_HI, COND_LS, COND_CARRY_CLR, COND_CARRY_SET,
        COND_NE, COND_EQ, COND_VC, COND_VS, COND_PL, COND_MI,
        COND_GE, COND_LT, COND_GT, COND_LE
    } lbsd_cond_type;

    typedef enum logic {ST_IDLE, ST_DIV_RUN} lbsd_state_type;

    typedef struct packed {
        logic x;
        logic n;
        logic z;
        logic v;
        logic c;
    } lbsd_flags_type;

    typedef struct packed {
        logic [15:0] op_word;
        logic [15:0] ext_word;
        logic [31:0] src_value;
        logic [31:0] instr_pc;
    } lbsd_issue_type;

    typedef struct packed {
        logic busy;
        logic done;
        logic [6:0] count;
        logic [32:0] rem;
        logic [63:0] quo;
    } lbsd_div_state_type;

    typedef struct packed {
        lbsd_state_type state;
        logic busy;
        logic [7:0][31:0] dreg;
        lbsd_flags_type flags;
        logic [31:0] next_pc;
        logic [31:0] rd_data;
        logic done;
        logic branch_taken;
        logic div_zero_trap;
        logic illegal_op;
        logic div_start;
        logic word_form;
        logic neg_q;
        logic neg_r;
        logic write_rem;
        logic [2:0] quo_reg;
        logic [2:0] rem_reg;
        logic [63:0] dividend;
        logic [31:0] divisor;
    } lbsd_core_type;

    localparam lbsd_core_type CORE_RESET = '0;
    localparam lbsd_div_state_type DIV_RESET = '0;

endpackage : lbsd_pkg

// file: lbsd_cond_eval.sv
// Condition test evaluator for the decrement loop branch
`timescale 1ns/1ps
module lbsd_cond_eval (
    input logic [3:0] condition_select,
    input lbsd_pkg::lbsd_flags_type flags,
    output logic result
);

    always_comb begin
        case (lbsd_pkg::lbsd_cond_type'(condition_select))
            lbsd_pkg::COND_TRUE: result = 1'b1;
            lbsd_pkg::COND_FALSE: result = 1'b0;
            lbsd_pkg::COND_HI: result = !flags.c && !flags.z;
            lbsd_pkg::COND_LS: result = flags.c || flags.z;
            lbsd_pkg::COND_CARRY_CLR: result = !flags.c;
            lbsd_pkg::COND_CARRY_SET: result = flags.c;
            lbsd_pkg::COND_NE: result = !flags.z;
            lbsd_pkg::COND_EQ: result = flags.z;
            lbsd_pkg::COND_VC: result = !flags.v;
            lbsd_pkg::COND_VS: result = flags.v;
            lbsd_pkg::COND_PL: result = !flags.n;
            lbsd_pkg::COND_MI: result = flags.n;
            lbsd_pkg::COND_GE: result = flags.n == flags.v;
            lbsd_pkg::COND_LT: result = flags.n != flags.v;
            lbsd_pkg::COND_GT: result = !flags.z && (flags.n == flags.v);
            lbsd_pkg::COND_LE: result = flags.z || (flags.n != flags.v);
            default: result = 1'b0;
        endcase
    end

endmodule : lbsd_cond_eval

// file: lbsd_mag_divider.sv
// Unsigned restoring divider, 64-bit dividend by 32-bit divisor, one bit per cycle
`timescale 1ns/1ps
module lbsd_mag_divider (
    input logic clk,
    input logic reset,
    input logic start,
    input logic [63:0] dividend,
    input logic [31:0] divisor,
    output logic done,
    output logic [63:0] quotient,
    output logic [31:0] remainder
);

    lbsd_pkg::lbsd_div_state_type st;
    lbsd_pkg::lbsd_div_state_type next_st;
    logic [32:0] trial;
    logic quo_bit;

    // Divisor must stay stable while busy; the caller holds it in flops
    always_comb begin
        trial = 33'h0_0000_0000;
        quo_bit = 1'b0;
        next_st = st;
        next_st.done = 1'b0;
        if (st.busy) begin
            trial = {st.rem[31:0], st.quo[63]};
            quo_bit = trial >= {1'b0, divisor};
            next_st.rem = quo_bit ? trial - {1'b0, divisor} : trial;
            next_st.quo = {st.quo[62:0], quo_bit};
            next_st.count = st.count + 7'h01;
            if (st.count == lbsd_pkg::DIV_LAST_STEP) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
        end else if (start) begin
            next_st.busy = 1'b1;
            next_st.count = lbsd_pkg::DIV_COUNT_RESET;
            next_st.rem = 33'h0_0000_0000;
            next_st.quo = dividend;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= lbsd_pkg::DIV_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign done = st.done;
    assign quotient = st.quo;
    assign remainder = st.rem[31:0];

endmodule : lbsd_mag_divider

// file: tb_top.sv
// Self-checking bench for the loop-branch and signed-divide execution unit
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic issue_valid = 1'b0;
    lbsd_pkg::lbsd_issue_type issue = '0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic done;
    logic [31:0] next_pc;
    logic branch_taken;
    logic div_zero_trap;
    logic illegal_op;
    logic busy;
    int n_mismatch = 0;
    int samples_checked = 0;
    int lat;
    logic [31:0] pc_seen;
    logic [15:0] bad_op [3] = '{16'h83C8, 16'h83FD, 16'h4C7C};
    logic busy_seen;
    // Truth of each condition code, bit per code, under the matching flag setting {X,N,Z,V,C}
    logic [4:0] cond_flags [3] = '{5'h19, 5'h06, 5'h00};
    logic [15:0] cond_truth [3] = '{16'hA969, 16'hA699, 16'h5555};

    always #10 clk = ~clk;

    lbsd_exec_unit u_dut (.clk(clk), .reset(reset), .issue_valid(issue_valid), .issue(issue),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .done(done), .next_pc(next_pc), .branch_taken(branch_taken),
        .div_zero_trap(div_zero_trap), .illegal_op(illegal_op), .busy(busy));

    task automatic report_and_stop();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // Read data is only valid in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] mask, input string what);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata & mask, exp, what);
    endtask : rd_chk

    // Events at completion are packed as {branch, trap, illegal}; busy must be low by then
    task automatic do_op(input logic [15:0] op, input logic [15:0] ext, input logic [31:0] src,
                         input logic [31:0] pc, input logic [2:0] exp_evt);
        int i;
        @(posedge clk);
        issue_valid <= 1'b1;
        issue <= '{op_word: op, ext_word: ext, src_value: src, instr_pc: pc};
        @(posedge clk);
        issue_valid <= 1'b0;
        #1;
        busy_seen = busy;
        for (i = 0; i < 100 && done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (done !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: no completion", $time);
            report_and_stop();
        end
        lat = i + 1;
        pc_seen = next_pc;
        chk({28'h0, busy, branch_taken, div_zero_trap, illegal_op}, {29'h0, exp_evt}, "events");
    endtask : do_op

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd_chk(4'h3, 32'h0, 32'hFFFF_FFFF, "d3 reset");
        rd_chk(4'h8, 32'h0, 32'hFFFF_FFFF, "flags reset");
        rd_chk(4'h9, 32'h0, 32'hFFFF_FFFF, "status idle");
        wr(4'hA, 32'hFFFF_FFFF);
        rd_chk(4'hA, 32'h0, 32'hFFFF_FFFF, "unmapped");
        // Loop: X, Z and C set beforehand so an unwanted flag update shows
        wr(4'h2, 32'h1234_0005);
        wr(4'h8, 32'h0000_0015);
        do_op(16'h51CA, 16'hFFF0, 32'h0, 32'h0000_0100, 3'b100);
        chk(pc_seen, 32'h0000_00F2, "branch target");
        chk(lat, 32'h1, "loop latency");
        chk(busy_seen, 32'h0, "loop busy");
        rd_chk(4'h2, 32'h1234_0004, 32'hFFFF_FFFF, "count dec");
        rd_chk(4'h8, 32'h15, 32'hFFFF_FFFF, "loop flags");
        do_op(16'h50CA, 16'hFFF0, 32'h0, 32'h0000_0200, 3'b000);
        chk(pc_seen, 32'h0000_0204, "true falls on");
        rd_chk(4'h2, 32'h1234_0004, 32'hFFFF_FFFF, "count kept");
        do_op(16'h57CA, 16'h0040, 32'h0, 32'h0000_0300, 3'b000);
        do_op(16'h56CA, 16'h0040, 32'h0, 32'h0000_0300, 3'b100);
        chk(pc_seen, 32'h0000_0342, "forward target");
        wr(4'h2, 32'h1234_0000);
        do_op(16'h51CA, 16'hFFF0, 32'h0, 32'h0000_0400, 3'b000);
        chk(pc_seen, 32'h0000_0404, "wrap falls on");
        rd_chk(4'h2, 32'h1234_FFFF, 32'hFFFF_FFFF, "low half wrap");
        // Every condition against three flag settings: branch exactly when the test is false
        wr(4'h5, 32'h0000_0100);
        foreach (cond_flags[f]) begin
            wr(4'h8, {27'h0, cond_flags[f]});
            for (int c = 0; c < 16; c++) begin
                do_op({4'h5, c[3:0], 5'h19, 3'h5}, 16'h0010, 32'h0, 32'h0, {~cond_truth[f][c], 2'b00});
            end
        end
        rd_chk(4'h5, 32'h0000_00E8, 32'hFFFF_FFFF, "sweep count");
        // Word divide, negative dividend, divisor from a data register
        wr(4'h8, 32'h0000_0010);
        wr(4'h1, 32'hFFFF_FFF9);
        wr(4'h0, 32'h0000_0002);
        do_op(16'h83C0, 16'h0, 32'h0, 32'h0, 3'b000);
        chk(lat, 32'd67, "divide latency");
        chk(busy_seen, 32'h1, "busy during divide");
        rd_chk(4'h1, 32'hFFFF_FFFD, 32'hFFFF_FFFF, "word q r");
        rd_chk(4'h8, 32'h18, 32'hFFFF_FFFF, "word flags");
        wr(4'h1, 32'h0010_0000);
        do_op(16'h83FC, 16'h0, 32'h1, 32'h0, 3'b000);
        rd_chk(4'h1, 32'h0010_0000, 32'hFFFF_FFFF, "ovf kept");
        rd_chk(4'h8, 32'h12, 32'h13, "ovf flags");
        do_op(16'h83FC, 16'h0, 32'h0, 32'h0, 3'b010);
        rd_chk(4'h1, 32'h0010_0000, 32'hFFFF_FFFF, "trap kept");
        // Long divide, 64-bit pair dividend first, then 32-bit dividend forms
        wr(4'h8, 32'h0000_0010);
        wr(4'h4, 32'h0000_0001);
        wr(4'h3, 32'h0000_0005);
        do_op(16'h4C7C, 16'h3C04, 32'h10, 32'h0, 3'b000);
        rd_chk(4'h3, 32'h1000_0000, 32'hFFFF_FFFF, "pair q");
        rd_chk(4'h4, 32'h0000_0005, 32'hFFFF_FFFF, "pair r");
        rd_chk(4'h8, 32'h10, 32'hFFFF_FFFF, "pair flags");
        wr(4'h3, 32'hFFFF_FFEF);
        do_op(16'h4C7C, 16'h3804, 32'h5, 32'h0, 3'b000);
        rd_chk(4'h3, 32'hFFFF_FFFD, 32'hFFFF_FFFF, "long q");
        rd_chk(4'h4, 32'hFFFF_FFFE, 32'hFFFF_FFFF, "long r");
        rd_chk(4'h8, 32'h18, 32'hFFFF_FFFF, "neg flags");
        wr(4'h3, 32'h0000_0003);
        do_op(16'h4C7C, 16'h3804, 32'h5, 32'h0, 3'b000);
        rd_chk(4'h8, 32'h14, 32'hFFFF_FFFF, "zero flags");
        rd_chk(4'h4, 32'h0000_0003, 32'hFFFF_FFFF, "long r pos");
        wr(4'h3, 32'h0000_0064);
        do_op(16'h4C7C, 16'h3803, 32'h7, 32'h0, 3'b000);
        rd_chk(4'h3, 32'h0000_000E, 32'hFFFF_FFFF, "q only");
        rd_chk(4'h4, 32'h0000_0003, 32'hFFFF_FFFF, "other kept");
        // Early overflow on the pair form
        wr(4'h4, 32'h1000_0000);
        wr(4'h3, 32'h0000_0000);
        do_op(16'h4C7C, 16'h3C04, 32'h2, 32'h0, 3'b000);
        rd_chk(4'h3, 32'h0, 32'hFFFF_FFFF, "long ovf q");
        rd_chk(4'h4, 32'h1000_0000, 32'hFFFF_FFFF, "long ovf r");
        rd_chk(4'h8, 32'h12, 32'h13, "long ovf flags");
        foreach (bad_op[k]) begin
            do_op(bad_op[k], 16'h0, 32'h1, 32'h0, 3'b001);
        end
        report_and_stop();
    end
endmodule : tb_top
